// ### verilog/bid_pkg.sv
// Constants, types and encodings shared by the instruction decoder files.
package bid_pkg;

	localparam int OSC_PER_CYCLE = 4;
	localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_CYCLE - 1);

	localparam logic [11:0] NOP_WORD = 12'h000;
	localparam logic [10:0] RESET_PC = 11'h000;

	// Special file addresses decoded inside the block.
	localparam logic [4:0] PCL_ADDR = 5'h02;
	localparam logic [4:0] TIMER_ADDR = 5'h01;
	localparam logic [4:0] STATUS_ADDR = 5'h03;
	localparam logic [4:0] IO_PORT_ADDR = 5'h06;
	localparam logic [2:0] DIR_PORT_SEL = 3'h6;

	// Status register bit positions.
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_PD = 3;
	localparam int ST_TO = 4;
	localparam int ST_PA_LO = 5;
	localparam int ST_PA_HI = 6;
	localparam logic [7:0] STATUS_RESET = 8'h18;
	localparam logic [7:0] STATUS_SW_MASK = 8'he7;

	localparam int OPT_PSA = 3;
	localparam logic [7:0] OPTION_RESET = 8'hff;
	localparam logic [7:0] DIRECTION_LATCH_LOAD_RESET = 8'hff;

	// Avalon register byte offsets.
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_ACC = 4'h8;
	localparam logic [3:0] REG_PC = 4'hc;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_WAKE = 1;
	localparam logic CTRL_RUN_RESET = 1'b1;
	localparam int STAT_STANDBY = 8;

	typedef enum logic [3:0] {
		ALU_MOVB, ALU_MOVA, ALU_CLR, ALU_ADD, ALU_SUB, ALU_AND,
		ALU_OR, ALU_XOR, ALU_COM, ALU_INC, ALU_DEC, ALU_RL,
		ALU_RR, ALU_SWAP, ALU_BCLR, ALU_BSET
	} bid_alu_op_t;

	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic we;
	} bid_file_req_t;

	typedef struct packed {
		logic [7:0] res;
		logic c;
		logic dc;
		logic z;
	} bid_alu_out_t;

endpackage : bid_pkg

// ### verilog/bid_cycle_div.sv
// Divider that marks the last oscillator period of each instruction cycle.
`timescale 1ns/1ps
module bid_cycle_div
	import bid_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Cycle marker
	output logic cycle_en_o
);
	import bid_pkg::*;

	logic [1:0] phase_ff;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			phase_ff <= 2'h0;
		else
			phase_ff <= phase_ff + 2'h1;
	end

	assign cycle_en_o = (phase_ff == PHASE_LAST);

endmodule : bid_cycle_div

// ### verilog/bid_alu.sv
// Eight-bit arithmetic and logic unit with carry, digit carry and zero.
`timescale 1ns/1ps
module bid_alu
	import bid_pkg::*;
(
	// Operation and operands
	input bid_pkg::bid_alu_op_t op_i,
	input wire logic [7:0] acc_i,
	input wire logic [7:0] opnd_i,
	input wire logic [2:0] bit_i,
	input wire logic carry_i,
	// Result
	output bid_pkg::bid_alu_out_t out_o
);
	import bid_pkg::*;

	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] mask;

	always_comb
	begin
		mask = 8'h01 << bit_i;
		sum = 9'h000;
		nib = 5'h00;
		out_o.c = carry_i;
		out_o.dc = 1'b0;
		unique case (op_i)
			ALU_MOVB: out_o.res = opnd_i;
			ALU_MOVA: out_o.res = acc_i;
			ALU_CLR: out_o.res = 8'h00;
			ALU_ADD:
			begin
				sum = {1'b0, acc_i} + {1'b0, opnd_i};
				nib = {1'b0, acc_i[3:0]} + {1'b0, opnd_i[3:0]};
				out_o.res = sum[7:0];
				out_o.c = sum[8];
				out_o.dc = nib[4];
			end
			ALU_SUB:
			begin
				// Carry set means no borrow.
				sum = {1'b0, opnd_i} + {1'b0, ~acc_i} + 9'h001;
				nib = {1'b0, opnd_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
				out_o.res = sum[7:0];
				out_o.c = sum[8];
				out_o.dc = nib[4];
			end
			ALU_AND: out_o.res = acc_i & opnd_i;
			ALU_OR: out_o.res = acc_i | opnd_i;
			ALU_XOR: out_o.res = acc_i ^ opnd_i;
			ALU_COM: out_o.res = ~opnd_i;
			ALU_INC: out_o.res = opnd_i + 8'h01;
			ALU_DEC: out_o.res = opnd_i - 8'h01;
			ALU_RL:
			begin
				out_o.res = {opnd_i[6:0], carry_i};
				out_o.c = opnd_i[7];
			end
			ALU_RR:
			begin
				out_o.res = {carry_i, opnd_i[7:1]};
				out_o.c = opnd_i[0];
			end
			ALU_SWAP: out_o.res = {opnd_i[3:0], opnd_i[7:4]};
			ALU_BCLR: out_o.res = opnd_i & ~mask;
			ALU_BSET: out_o.res = opnd_i | mask;
		endcase
		out_o.z = (out_o.res == 8'h00);
	end

endmodule : bid_alu

// ### verilog/bid_decoder.sv
// Instruction decoder and executor for the 8-bit accumulator core.
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
module bid_decoder
	import bid_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Program memory fetch
	output logic [10:0] pc_o,
	input wire logic [11:0] instr_i,
	// Core register file
	output logic [4:0] file_raddr_o,
	input wire logic [7:0] file_rdata_i,
	output bid_pkg::bid_file_req_t file_wr_o,
	// Port pins, direction and timer side effects
	input wire logic [7:0] io_pins_i,
	output logic [7:0] dir_latch_o,
	output logic [7:0] option_o,
	output logic prescaler_clr_o,
	output logic standby_o,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	import bid_pkg::*;

	logic rst_meta_ff;
	logic rst_n_ff;
	logic cycle_en;
	logic exec_en;
	logic [11:0] ir_ff;
	logic [10:0] pc_ff;
	logic [10:0] stack_ff [0:1];
	logic [7:0] acc_ff;
	logic [7:0] status_ff;
	logic [7:0] dir_ff;
	logic [7:0] option_ff;
	logic standby_ff;
	logic run_ff;
	bid_file_req_t file_wr_ff;
	logic prescaler_clr_ff;
	logic ack_ff;
	logic [31:0] rdata_ff;

	// Decoded controls.
	bid_alu_op_t alu_op;
	bid_alu_out_t alu_out;
	logic use_lit;
	logic wr_f;
	logic wr_w;
	logic upd_z;
	logic upd_cdc;
	logic upd_c;
	logic skip_zero;
	logic skip_clr;
	logic skip_set;
	logic is_call;
	logic is_unconditional_jump;
	logic is_ret;
	logic is_sleep;
	logic is_clrwdt;
	logic is_option;
	logic is_dir;
	logic [7:0] file_opnd;
	logic [7:0] opnd;
	logic skip_taken;
	logic pcl_write;
	logic wake_req;
	logic bus_req;

	wire [4:0] f_addr = ir_ff[4:0];
	wire [2:0] b_sel = ir_ff[7:5];
	wire d_bit = ir_ff[5];
	wire [7:0] k8 = ir_ff[7:0];
	wire [1:0] page = status_ff[ST_PA_HI:ST_PA_LO];

	// Reset release through two flip-flops.
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rst_meta_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_n_ff <= rst_meta_ff;
		end
	end

	bid_cycle_div u_div (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_ff),
		.cycle_en_o(cycle_en)
	);

	assign exec_en = cycle_en & run_ff & ~standby_ff;

	always_comb
	begin
		alu_op = ALU_MOVB;
		use_lit = 1'b0;
		wr_f = 1'b0;
		wr_w = 1'b0;
		upd_z = 1'b0;
		upd_cdc = 1'b0;
		upd_c = 1'b0;
		skip_zero = 1'b0;
		skip_clr = 1'b0;
		skip_set = 1'b0;
		is_call = 1'b0;
		is_unconditional_jump = 1'b0;
		is_ret = 1'b0;
		is_sleep = 1'b0;
		is_clrwdt = 1'b0;
		is_option = 1'b0;
		is_dir = 1'b0;
		unique case (ir_ff[11:10])
			2'b00:
			begin
				wr_f = d_bit;
				wr_w = ~d_bit;
				upd_z = 1'b1;
				unique case (ir_ff[9:6])
					4'h0:
					begin
						upd_z = 1'b0;
						wr_w = 1'b0;
						alu_op = ALU_MOVA;
						is_option = (ir_ff[5:0] == 6'h02);
						is_sleep = (ir_ff[5:0] == 6'h03);
						is_clrwdt = (ir_ff[5:0] == 6'h04);
						is_dir = (ir_ff[5:3] == 3'h0) &&
							(ir_ff[2:0] == DIR_PORT_SEL);
					end
					4'h1: alu_op = ALU_CLR;
					4'h2:
					begin
						alu_op = ALU_SUB;
						upd_cdc = 1'b1;
					end
					4'h3: alu_op = ALU_DEC;
					4'h4: alu_op = ALU_OR;
					4'h5: alu_op = ALU_AND;
					4'h6: alu_op = ALU_XOR;
					4'h7:
					begin
						alu_op = ALU_ADD;
						upd_cdc = 1'b1;
					end
					4'h8: alu_op = ALU_MOVB;
					4'h9: alu_op = ALU_COM;
					4'ha: alu_op = ALU_INC;
					4'hb:
					begin
						alu_op = ALU_DEC;
						upd_z = 1'b0;
						skip_zero = 1'b1;
					end
					4'hc:
					begin
						alu_op = ALU_RR;
						upd_z = 1'b0;
						upd_c = 1'b1;
					end
					4'hd:
					begin
						alu_op = ALU_RL;
						upd_z = 1'b0;
						upd_c = 1'b1;
					end
					4'he:
					begin
						alu_op = ALU_SWAP;
						upd_z = 1'b0;
					end
					4'hf:
					begin
						alu_op = ALU_INC;
						upd_z = 1'b0;
						skip_zero = 1'b1;
					end
				endcase
			end
			2'b01:
			begin
				unique case (ir_ff[9:8])
					2'b00:
					begin
						alu_op = ALU_BCLR;
						wr_f = 1'b1;
					end
					2'b01:
					begin
						alu_op = ALU_BSET;
						wr_f = 1'b1;
					end
					2'b10: skip_clr = 1'b1;
					2'b11: skip_set = 1'b1;
				endcase
			end
			2'b10:
			begin
				use_lit = 1'b1;
				unique case (ir_ff[9:8])
					2'b00:
					begin
						is_ret = 1'b1;
						wr_w = 1'b1;
					end
					2'b01: is_call = 1'b1;
					default: is_unconditional_jump = 1'b1;
				endcase
			end
			2'b11:
			begin
				use_lit = 1'b1;
				wr_w = 1'b1;
				upd_z = (ir_ff[9:8] != 2'b00);
				unique case (ir_ff[9:8])
					2'b00: alu_op = ALU_MOVB;
					2'b01: alu_op = ALU_OR;
					2'b10: alu_op = ALU_AND;
					2'b11: alu_op = ALU_XOR;
				endcase
			end
		endcase
	end

	// The I/O port operand is the pin levels, so a read-modify-write
	// never copies a stale latch value back out.
	always_comb
	begin
		if (f_addr == IO_PORT_ADDR)
			file_opnd = io_pins_i;
		else if (f_addr == STATUS_ADDR)
			file_opnd = status_ff;
		else if (f_addr == PCL_ADDR)
			file_opnd = pc_ff[7:0];
		else
			file_opnd = file_rdata_i;
	end

	assign opnd = use_lit ? k8 : file_opnd;

	bid_alu u_alu (
		.op_i(alu_op),
		.acc_i(acc_ff),
		.opnd_i(opnd),
		.bit_i(b_sel),
		.carry_i(status_ff[ST_C]),
		.out_o(alu_out)
	);

	assign skip_taken = (skip_zero & alu_out.z) |
		(skip_clr & ~opnd[b_sel]) | (skip_set & opnd[b_sel]);
	assign pcl_write = wr_f && (f_addr == PCL_ADDR);

	// Instruction register: a jump, call, return, PCL write or taken skip
	// flushes the word fetched during this cycle; a plain increment does not.
	always_ff @(posedge sys_clk_i or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			ir_ff <= NOP_WORD;
		else if (exec_en)
		begin
			if (skip_taken | is_unconditional_jump | is_call | is_ret | pcl_write)
				ir_ff <= NOP_WORD;
			else
				ir_ff <= instr_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			pc_ff <= RESET_PC;
		else if (exec_en)
		begin
			if (is_unconditional_jump)
				pc_ff <= {page, ir_ff[8:0]};
			else if (is_call)
				pc_ff <= {page, 1'b0, k8};
			else if (is_ret)
				pc_ff <= stack_ff[0];
			else if (pcl_write)
				pc_ff <= {page, 1'b0, alu_out.res};
			else
				pc_ff <= pc_ff + 11'h001;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			stack_ff[0] <= RESET_PC;
			stack_ff[1] <= RESET_PC;
		end
		else if (exec_en & is_call)
		begin
			stack_ff[1] <= stack_ff[0];
			stack_ff[0] <= pc_ff;
		end
		else if (exec_en & is_ret)
			stack_ff[0] <= stack_ff[1];
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			acc_ff <= 8'h00;
		else if (exec_en & wr_w)
			acc_ff <= is_ret ? k8 : alu_out.res;
	end

	// Flag updates take priority over a file write to the status byte.
	always_ff @(posedge sys_clk_i or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			status_ff <= STATUS_RESET;
		else if (exec_en)
		begin
			if (wr_f && (f_addr == STATUS_ADDR))
				status_ff <= (alu_out.res & STATUS_SW_MASK) |
					(status_ff & ~STATUS_SW_MASK);
			if (upd_z)
				status_ff[ST_Z] <= alu_out.z;
			if (upd_cdc)
			begin
				status_ff[ST_C] <= alu_out.c;
				status_ff[ST_DC] <= alu_out.dc;
			end
			if (upd_c)
				status_ff[ST_C] <= alu_out.c;
			if (is_sleep)
			begin
				status_ff[ST_TO] <= 1'b1;
				status_ff[ST_PD] <= 1'b0;
			end
			if (is_clrwdt)
			begin
				status_ff[ST_TO] <= 1'b1;
				status_ff[ST_PD] <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			dir_ff <= DIRECTION_LATCH_LOAD_RESET;
		else if (exec_en & is_dir)
			dir_ff <= acc_ff;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			option_ff <= OPTION_RESET;
		else if (exec_en & is_option)
			option_ff <= acc_ff;
	end

	// Ordinary file writes leave as a registered one-cycle request.
	always_ff @(posedge sys_clk_i or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			file_wr_ff <= '0;
			prescaler_clr_ff <= 1'b0;
		end
		else
		begin
			file_wr_ff.we <= exec_en & wr_f &
				(f_addr != STATUS_ADDR) & (f_addr != PCL_ADDR);
			file_wr_ff.addr <= f_addr;
			file_wr_ff.wdata <= alu_out.res;
			prescaler_clr_ff <= exec_en & wr_f & (f_addr == TIMER_ADDR) &
				~option_ff[OPT_PSA];
		end
	end

	assign wake_req = bus_req & avs_write_i & (avs_address_i == REG_CTRL) &
		avs_byteenable_i[0] & avs_writedata_i[CTRL_WAKE];

	always_ff @(posedge sys_clk_i or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			standby_ff <= 1'b0;
		else if (exec_en & is_sleep)
			standby_ff <= 1'b1;
		else if (wake_req)
			standby_ff <= 1'b0;
	end

	// Avalon slave: every access completes one cycle after it starts.
	assign bus_req = (avs_read_i | avs_write_i) & ~ack_ff;
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_ff;

	always_ff @(posedge sys_clk_i or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			ack_ff <= 1'b0;
			run_ff <= CTRL_RUN_RESET;
		end
		else
		begin
			ack_ff <= bus_req;
			if (bus_req & avs_write_i & (avs_address_i == REG_CTRL) &
				avs_byteenable_i[0])
				run_ff <= avs_writedata_i[CTRL_RUN];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			rdata_ff <= 32'h0000_0000;
		else if (bus_req & avs_read_i)
		begin
			unique case (avs_address_i)
				REG_CTRL: rdata_ff <= {31'h0, run_ff};
				REG_STAT: rdata_ff <= {23'h0, standby_ff, status_ff};
				REG_ACC: rdata_ff <= {8'h00, dir_ff, option_ff, acc_ff};
				REG_PC: rdata_ff <= {21'h0, pc_ff};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	assign avs_readdata_o = rdata_ff;
	assign pc_o = pc_ff;
	assign file_raddr_o = f_addr;
	assign file_wr_o = file_wr_ff;
	assign dir_latch_o = dir_ff;
	assign option_o = option_ff;
	assign prescaler_clr_o = prescaler_clr_ff;
	assign standby_o = standby_ff;

endmodule : bid_decoder

// ### tb/bid_decoder_monitor.sv
// Port assertions for the instruction decoder.
`timescale 1ns/1ps
module bid_decoder_monitor
	import bid_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Observed outputs
	input wire logic [10:0] pc_o,
	input wire logic [4:0] file_raddr_o,
	input bid_pkg::bid_file_req_t file_wr_o,
	input wire logic [7:0] dir_latch_o,
	input wire logic [7:0] option_o,
	input wire logic prescaler_clr_o,
	input wire logic standby_o
);
	import bid_pkg::*;

	default clocking mon_cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);

	a_wr_single: assert property (file_wr_o.we |=> !file_wr_o.we [*3])
		else $error("file write repeated inside one instruction cycle");
	a_wr_addr: assert property (file_wr_o.we |->
		file_wr_o.addr == $past(file_raddr_o))
		else $error("file write address differs from decoded address");
	a_clr_only: assert property (prescaler_clr_o |-> file_wr_o.we &&
		file_wr_o.addr == TIMER_ADDR && !option_o[OPT_PSA])
		else $error("prescaler cleared without a timer write");
	a_clr_cause: assert property (file_wr_o.we &&
		file_wr_o.addr == TIMER_ADDR && !option_o[OPT_PSA] |-> prescaler_clr_o)
		else $error("timer write left prescaler running");
	a_pc_stands: assert property ($changed(pc_o) |=> $stable(pc_o) [*3])
		else $error("fetch address moved inside an instruction cycle");
	a_dir_stands: assert property ($changed(dir_latch_o) |=>
		$stable(dir_latch_o) [*3])
		else $error("direction latches moved inside an instruction cycle");
	a_sb_frozen: assert property (standby_o [*2] |-> $stable(pc_o))
		else $error("fetch address moved during standby");
	a_sb_quiet: assert property (standby_o [*2] |-> !file_wr_o.we)
		else $error("file write during standby");
endmodule : bid_decoder_monitor

bind bid_decoder bid_decoder_monitor u_mon (
	.sys_clk_i(sys_clk_i),
	.resetn_i(resetn_i),
	.pc_o(pc_o),
	.file_raddr_o(file_raddr_o),
	.file_wr_o(file_wr_o),
	.dir_latch_o(dir_latch_o),
	.option_o(option_o),
	.prescaler_clr_o(prescaler_clr_o),
	.standby_o(standby_o)
);

// ### tb/bid_mem_model.sv
// Program memory and file register model facing the decoder.
`timescale 1ns/1ps
module bid_mem_model
	import bid_pkg::*;
(
	// Clock
	input wire logic sys_clk_i,
	// Fetch
	input wire logic [10:0] pc_i,
	output logic [11:0] instr_o,
	// File registers
	input wire logic [4:0] raddr_i,
	output logic [7:0] rdata_o,
	input bid_pkg::bid_file_req_t wr_i
);
	logic [11:0] prog [2048];
	logic [7:0] regs [32];

	assign instr_o = prog[pc_i];
	assign rdata_o = regs[raddr_i];

	always @(posedge sys_clk_i)
	begin
		if (wr_i.we === 1'b1)
		begin
			regs[wr_i.addr] <= wr_i.wdata;
		end
	end
endmodule : bid_mem_model

// ### tb/bid_decoder_test.sv
// Bench that runs a short program and checks results over the bus.
`timescale 1ns/1ps
module bid_decoder_test;
	import bid_pkg::*;

	localparam logic [11:0] PROG [24] = '{12'hc8f, 12'h1f0, 12'h1d1,
		12'h132, 12'h193, 12'hcff, 12'he0f, 12'hd00, 12'hf0f, 12'hc81,
		12'h374, 12'h315, 12'h5f6, 12'h417, 12'h2f8, 12'h03c, 12'h3d9,
		12'h67a, 12'h03d, 12'h77a, 12'h03e, 12'h006, 12'h920, 12'hb40};
	localparam logic [11:0] FAR [7] = '{12'h03b, 12'hc00, 12'h002,
		12'h021, 12'h226, 12'hc48, 12'h022};
	localparam logic [12:0] PRE [10] = '{13'h1071, 13'h1101, 13'h1390,
		13'h1480, 13'h1502, 13'h17ff, 13'h1801, 13'h1905, 13'h013c, 13'h0600};
	localparam logic [12:0] EXF [14] = '{13'h1000, 13'h1101, 13'h1290,
		13'h1400, 13'h1680, 13'h17fe, 13'h1800, 13'h1905, 13'h1b5a,
		13'h1c00, 13'h1d00, 13'h1e06, 13'h06a5, 13'h0100};

	logic sys_clk_i;
	logic resetn_i;
	logic [10:0] pc;
	logic [11:0] instr;
	logic [4:0] raddr;
	logic [7:0] rdata;
	bid_file_req_t fwr;
	logic [7:0] dir;
	logic [7:0] opt;
	logic pclr;
	logic standby;
	logic [3:0] address;
	logic rd;
	logic wr;
	logic [31:0] wdata;
	logic [31:0] rdat;
	logic waitreq;
	logic [31:0] d;
	logic [31:0] d2;
	int num_errors = 0;
	int n_tests = 0;
	int n_clr = 0;

	bid_decoder dut (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.pc_o(pc),
		.instr_i(instr),
		.file_raddr_o(raddr),
		.file_rdata_i(rdata),
		.file_wr_o(fwr),
		.io_pins_i(8'ha5),
		.dir_latch_o(dir),
		.option_o(opt),
		.prescaler_clr_o(pclr),
		.standby_o(standby),
		.avs_address_i(address),
		.avs_read_i(rd),
		.avs_write_i(wr),
		.avs_writedata_i(wdata),
		.avs_byteenable_i(4'hf),
		.avs_readdata_o(rdat),
		.avs_waitrequest_o(waitreq)
	);

	bid_mem_model mem (
		.sys_clk_i(sys_clk_i),
		.pc_i(pc),
		.instr_o(instr),
		.raddr_i(raddr),
		.rdata_o(rdata),
		.wr_i(fwr)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	// One bus access; waitrequest and read data are taken at each rising
	// edge, and the request is held until waitrequest is seen low there.
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] wd, output logic [31:0] q);
		logic wt;
		@(posedge sys_clk_i);
		rd <= !w;
		wr <= w;
		address <= a;
		wdata <= wd;
		do
		begin
			@(posedge sys_clk_i);
			wt = waitreq;
			q = rdat;
		end
		while (wt !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	// File register contents and expected value of one table entry.
	function automatic logic [31:0] reg_seen(input int i);
		return {24'h0, mem.regs[EXF[i][12:8]]};
	endfunction : reg_seen

	function automatic logic [31:0] reg_want(input int i);
		return {24'h0, EXF[i][7:0]};
	endfunction : reg_want

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
		begin
			$display("No errors found");
		end
		else
		begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out

	initial
	begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	always @(posedge sys_clk_i)
	begin
		if (pclr === 1'b1)
		begin
			n_clr <= n_clr + 1;
		end
	end

	initial
	begin
		repeat (20000) @(posedge sys_clk_i);
		num_errors++;
		close_out();
	end

	initial
	begin
		resetn_i = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		address = 4'h0;
		wdata = 32'h0;
		for (int i = 0; i < 2048; i++) mem.prog[i] = NOP_WORD;
		for (int i = 0; i < 32; i++) mem.regs[i] = 8'h00;
		for (int i = 0; i < 24; i++) mem.prog[i] = PROG[i];
		for (int i = 0; i < 7; i++) mem.prog[320 + i] = FAR[i];
		for (int i = 0; i < 10; i++) mem.regs[PRE[i][12:8]] = PRE[i][7:0];
		mem.prog[32] = 12'h85a;
		mem.prog[72] = 12'hc77;
		mem.prog[73] = 12'h003;
		repeat (8) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		for (int i = 0; i < 4000 && standby !== 1'b1; i++)
			@(negedge sys_clk_i);
		chk({31'h0, standby}, 32'h1);
		for (int i = 0; i < 3; i++)
			chk(reg_seen(i), reg_want(i));
		chk(reg_seen(3), reg_want(3));
		for (int i = 4; i < 6; i++)
			chk(reg_seen(i), reg_want(i));
		for (int i = 6; i < 8; i++)
			chk(reg_seen(i), reg_want(i));
		chk(reg_seen(8), reg_want(8));
		for (int i = 9; i < 12; i++)
			chk(reg_seen(i), reg_want(i));
		chk(reg_seen(12), reg_want(12));
		chk(reg_seen(13), reg_want(13));
		chk(n_clr, 32'h1);
		chk({24'h0, dir}, 32'h00000006);
		bus(1'b0, REG_ACC, 32'h0, d);
		chk(d, 32'h00060077);
		bus(1'b0, REG_STAT, 32'h0, d);
		chk(d, 32'h00000112);
		bus(1'b1, REG_CTRL, 32'h3, d);
		repeat (2) @(negedge sys_clk_i);
		chk({31'h0, standby}, 32'h0);
		bus(1'b1, REG_CTRL, 32'h0, d);
		bus(1'b0, REG_PC, 32'h0, d);
		repeat (12) @(posedge sys_clk_i);
		bus(1'b0, REG_PC, 32'h0, d2);
		chk(d2, d);
		bus(1'b0, REG_CTRL, 32'h0, d);
		chk(d, 32'h0);
		bus(1'b0, 4'h2, 32'h0, d);
		chk(d, 32'h0);
		bus(1'b1, REG_STAT, 32'hffffffff, d);
		bus(1'b0, REG_STAT, 32'h0, d);
		chk(d, 32'h00000012);
		close_out();
	end
endmodule : bid_decoder_test
